// ===== i2csf_bus_model.sv
// Far-side model: other masters and slaves on the two wires.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module i2csf_bus_model (
	// Clock
	input  wire logic                 clk,
	// Bus wires, pulled up, clock parked high between frames
	output var logic                  sda,
	output var logic                  scl,
	// Engine events
	output var i2csf_pkg::i2csf_evt_t evt
);
	initial begin
		sda = 1'b1;
		scl = 1'b1;
		evt = '0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Start, or repeated start when called inside a frame
	task automatic start();
		sda <= 1'b1;
		hold(4);
		scl <= 1'b1;
		hold(4);
		sda <= 1'b0;
		hold(4);
		scl <= 1'b0;
		hold(8);
	endtask
	task automatic stop();
		sda <= 1'b0;
		hold(4);
		scl <= 1'b1;
		hold(4);
		sda <= 1'b1;
		hold(8);
	endtask
	// Busy is a level and carries over; stale data is inverted
	task automatic pulse(input i2csf_pkg::i2csf_evt_t e);
		evt <= e;
		@(posedge clk);
		evt <= '{busy: e.busy, rx_data: ~e.rx_data, default: '0};
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// ===== i2csf_cond_det.sv
// Start and stop condition detector for the two bus lines.
// Assumes raw pin levels, asynchronous to the module clock.

`timescale 1ns/1ps
`default_nettype none

module i2csf_cond_det (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Raw bus pins
	input  wire logic sda_in,
	input  wire logic scl_in,
	// Detected conditions
	output logic      start_pulse,
	output logic      stop_pulse
);

	// ==========================================================
	// Synchronisers; the second and third stages feed the detector
	logic sda_meta_reg;
	logic sda_sync_reg;
	logic sda_prev_reg;
	logic scl_meta_reg;
	logic scl_sync_reg;
	logic scl_prev_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sda_meta_reg <= 1'b1;
			sda_sync_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			scl_meta_reg <= 1'b1;
			scl_sync_reg <= 1'b1;
			scl_prev_reg <= 1'b1;
		end else begin
			sda_meta_reg <= sda_in;
			sda_sync_reg <= sda_meta_reg;
			sda_prev_reg <= sda_sync_reg;
			scl_meta_reg <= scl_in;
			scl_sync_reg <= scl_meta_reg;
			scl_prev_reg <= scl_sync_reg;
		end
	end

	// Data edge while clock stays high marks a condition
	assign start_pulse = scl_sync_reg & scl_prev_reg & sda_prev_reg
	                     & ~sda_sync_reg;
	assign stop_pulse  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg
	                     & sda_sync_reg;

endmodule

`default_nettype wire

// ===== i2csf_irq.sv
// Sticky interrupt status with mask and one level output.
// Assumes clear requests are already gated by a bus write.

`timescale 1ns/1ps
`default_nettype none

module i2csf_irq (
	// Clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	// Event and software controls
	input  wire logic [i2csf_pkg::NUM_IRQ-1:0]  set_evt,
	input  wire logic [i2csf_pkg::NUM_IRQ-1:0]  clr_bits,
	input  wire logic                           mask_wr,
	input  wire logic [i2csf_pkg::NUM_IRQ-1:0]  mask_data,
	// State
	output logic      [i2csf_pkg::NUM_IRQ-1:0]  stat_reg,
	output logic      [i2csf_pkg::NUM_IRQ-1:0]  mask_reg,
	output logic                                irq_reg
);

	// ==========================================================
	// Sticky bits; a new event beats a clear in the same cycle
	genvar i;
	generate
		for (i = 0; i < i2csf_pkg::NUM_IRQ; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!rst_n)
					stat_reg[i] <= 1'b0;
				else
					stat_reg[i] <= set_evt[i] | (stat_reg[i] & ~clr_bits[i]);
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mask_reg <= '0;
			irq_reg  <= 1'b0;
		end else begin
			if (mask_wr)
				mask_reg <= mask_data;
			irq_reg <= |(stat_reg & mask_reg);
		end
	end

endmodule

`default_nettype wire

// ===== i2csf_pkg.sv
// Shared constants and types for the serial bus status flag block.
// Assumes a 32-bit APB register port and an 8-bit address window.

package i2csf_pkg;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_STATUS   = 8'h00;
	localparam logic [7:0] OFS_CTRL     = 8'h04;
	localparam logic [7:0] OFS_TXD      = 8'h08;
	localparam logic [7:0] OFS_RXD      = 8'h0C;
	localparam logic [7:0] OFS_INT_STAT = 8'h10;
	localparam logic [7:0] OFS_INT_MASK = 8'h14;

	// ==========================================================
	// Status register bit positions
	localparam int BIT_NACK_SEEN  = 15;
	localparam int BIT_MTX_BUSY   = 14;
	localparam int BIT_COLLISION  = 10;
	localparam int BIT_GEN_CALL   = 9;
	localparam int BIT_TEN_MATCH  = 8;
	localparam int BIT_WR_COLL    = 7;
	localparam int BIT_RX_OVF     = 6;
	localparam int BIT_DATA_ADDR  = 5;
	localparam int BIT_STOP_SEEN  = 4;
	localparam int BIT_START_SEEN = 3;
	localparam int BIT_READ_DIR   = 2;
	localparam int BIT_RX_FULL    = 1;
	localparam int BIT_TX_FULL    = 0;

	// Control register
	localparam int BIT_ENABLE = 0;

	// ==========================================================
	// Interrupt sources, same layout in status and mask
	localparam int NUM_IRQ      = 8;
	localparam int IRQ_NACK     = 0;
	localparam int IRQ_RX_LOAD  = 1;
	localparam int IRQ_TX_DONE  = 2;
	localparam int IRQ_START    = 3;
	localparam int IRQ_STOP     = 4;
	localparam int IRQ_COLL     = 5;
	localparam int IRQ_WR_COLL  = 6;
	localparam int IRQ_RX_OVF   = 7;

	// ==========================================================
	// Reset values
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [7:0]  BYTE_ZERO = 8'h00;

	// Events from the bus engine, all one-cycle pulses except busy
	typedef struct packed {
		logic       ack_done;
		logic       ack_nack;
		logic       mtx_start;
		logic       collision;
		logic       gc_match;
		logic       ten_match;
		logic       addr_match;
		logic       rw_bit;
		logic       rx_valid;
		logic [7:0] rx_data;
		logic       tx_done;
		logic       busy;
	} i2csf_evt_t;

endpackage

// ===== i2csf_properties.sv
// Assertions on the top ports of the status flag block.
// Assumes a bind onto i2csf_top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module i2csf_properties (
	// Clock and reset
	input wire logic                  MCLK,
	input wire logic                  RST_N,
	// APB
	input wire logic                  PSEL,
	input wire logic                  PENABLE,
	input wire logic                  PWRITE,
	input wire logic [7:0]            PADDR,
	input wire logic [31:0]           PWDATA,
	input wire logic [31:0]           PRDATA,
	input wire logic                  PREADY,
	// Engine side
	input wire i2csf_pkg::i2csf_evt_t EVT,
	input wire logic                  ENABLE,
	input wire logic [7:0]            TX_DATA,
	input wire logic                  TX_FULL,
	input wire logic                  IRQ
);
	// ==========================================================
	// Decoded bus steps
	wire logic done_w = PSEL && PENABLE && PREADY;
	wire logic txd_wr = done_w && PWRITE && PADDR == i2csf_pkg::OFS_TXD;
	wire logic ctl_wr = done_w && PWRITE && PADDR == i2csf_pkg::OFS_CTRL;
	wire logic st_rd = done_w && !PWRITE && PADDR == i2csf_pkg::OFS_STATUS;
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	sequence s_load;
		txd_wr ##0 !EVT.busy;
	endsequence
	sequence s_refused;
		txd_wr ##0 EVT.busy;
	endsequence
	// ==========================================================
	// Properties
	property p_rst_zero;
		$rose(RST_N) |-> !TX_FULL && !IRQ && !ENABLE && !PREADY;
	endproperty
	property p_tx_set;
		s_load |=> TX_FULL && TX_DATA == $past(PWDATA[7:0]);
	endproperty
	property p_tx_discard;
		s_refused |=> $stable(TX_DATA);
	endproperty
	property p_tx_clr;
		EVT.tx_done && !txd_wr |=> !TX_FULL;
	endproperty
	property p_tx_hold;
		TX_FULL && !EVT.tx_done |=> TX_FULL;
	endproperty
	property p_enable;
		ctl_wr |=> ENABLE == $past(PWDATA[0]);
	endproperty
	property p_reserved;
		st_rd |-> PRDATA[31:16] == 16'h0000 && PRDATA[13:11] == 3'h0;
	endproperty
	property p_last_cond;
		st_rd |-> !(PRDATA[4] && PRDATA[3]);
	endproperty
	a_rst_zero: assert property (p_rst_zero) else $error("flags not zero");
	a_tx_set: assert property (p_tx_set) else $error("tx load lost");
	a_tx_discard: assert property (p_tx_discard) else $error("busy write");
	a_tx_clr: assert property (p_tx_clr) else $error("tx full stuck");
	a_tx_hold: assert property (p_tx_hold) else $error("tx full fell");
	a_enable: assert property (p_enable) else $error("enable wrong");
	a_reserved: assert property (p_reserved) else $error("bits nonzero");
	a_last_cond: assert property (p_last_cond) else $error("start+stop");
endmodule
`default_nettype wire
bind i2csf_top i2csf_properties i_i2csf_properties (
	.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .EVT(EVT), .ENABLE(ENABLE), .TX_DATA(TX_DATA),
	.TX_FULL(TX_FULL), .IRQ(IRQ));

// ===== i2csf_top.sv
// Status flag logic of a two-wire bus controller, master or slave.
// Assumes an APB master on MCLK, and a bus engine on MCLK that
// reports its events as one-cycle pulses in the event struct, busy as a level.
//
// The APB slave port and the placing of the registers were chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [R1] Master transmit: flag records slave not-acknowledge
// [R2] Transmit-busy flag spans eight bits and acknowledge
// [R3] Collision flag clears only by disabling module
// [R4] General call flag set on match, cleared on stop
// [R5] Ten-bit match flag set, cleared on stop
// [R6] Transmit write while busy discarded, sets flag
// [R7] Receive while still full sets overflow flag
// [R8] Data/address flag shows last received byte kind
// [R9] Stop flag set when last condition was stop
// [R10] Start flag set when last condition was start
// [R11] Direction flag from slave address read bit
// [R12] Receive full set on load, cleared on read
// [R13] Transmit full set on write, cleared when sent
// [R14] Unimplemented status bits read as zero
// [R15] Flags reset to zero; overflow and write collision clearable by writing zero
module i2csf_top (
	// Clock and reset
	input  wire logic                   MCLK,
	input  wire logic                   RST_N,
	// APB slave
	input  wire logic                   PSEL,
	input  wire logic                   PENABLE,
	input  wire logic                   PWRITE,
	input  wire logic [7:0]             PADDR,
	input  wire logic [31:0]            PWDATA,
	output logic      [31:0]            PRDATA,
	output logic                        PREADY,
	output logic                        PSLVERR,
	// Bus pins, sensed only
	input  wire logic                   SDA_IN,
	input  wire logic                   SCL_IN,
	// Bus engine events
	input  wire i2csf_pkg::i2csf_evt_t  EVT,
	// Towards the bus engine
	output logic                        ENABLE,
	output logic      [7:0]             TX_DATA,
	output logic                        TX_FULL,
	// Interrupt
	output logic                        IRQ
);

	// ==========================================================
	// Address decode
	function automatic logic reg_hit(input logic [7:0] a,
	                                 input logic [7:0] ofs);
		reg_hit = (a == ofs);
	endfunction

	typedef enum logic {ST_IDLE, ST_ANSWER} i2csf_apb_st_t;

	i2csf_apb_st_t state_reg;
	i2csf_apb_st_t state_next;

	logic        pready_reg;
	logic        pready_next;
	logic        pslverr_reg;
	logic        pslverr_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;

	wire hit_status = reg_hit(PADDR, i2csf_pkg::OFS_STATUS);
	wire hit_ctrl   = reg_hit(PADDR, i2csf_pkg::OFS_CTRL);
	wire hit_txd    = reg_hit(PADDR, i2csf_pkg::OFS_TXD);
	wire hit_rxd    = reg_hit(PADDR, i2csf_pkg::OFS_RXD);
	wire hit_ist    = reg_hit(PADDR, i2csf_pkg::OFS_INT_STAT);
	wire hit_imask  = reg_hit(PADDR, i2csf_pkg::OFS_INT_MASK);
	wire hit_any    = hit_status | hit_ctrl | hit_txd | hit_rxd
	                  | hit_ist | hit_imask;

	// A transfer completes at the edge where PREADY is seen high
	wire acc_fire = PSEL & PENABLE & pready_reg;
	wire wr_fire  = acc_fire & PWRITE;
	wire rd_fire  = acc_fire & ~PWRITE;

	wire wr_status = wr_fire & hit_status;
	wire wr_ctrl   = wr_fire & hit_ctrl;
	wire wr_txd    = wr_fire & hit_txd;
	wire wr_ist    = wr_fire & hit_ist;
	wire wr_imask  = wr_fire & hit_imask;
	wire rd_rxd    = rd_fire & hit_rxd;

	// ==========================================================
	// Condition detector and interrupt unit
	logic start_pulse;
	logic stop_pulse;

	i2csf_cond_det u_cond (
		.clk         (MCLK),
		.rst_n       (RST_N),
		.sda_in      (SDA_IN),
		.scl_in      (SCL_IN),
		.start_pulse (start_pulse),
		.stop_pulse  (stop_pulse)
	);

	logic [i2csf_pkg::NUM_IRQ-1:0] irq_set;
	logic [i2csf_pkg::NUM_IRQ-1:0] irq_stat;
	logic [i2csf_pkg::NUM_IRQ-1:0] irq_mask;
	logic                          irq_out;

	i2csf_irq u_irq (
		.clk       (MCLK),
		.rst_n     (RST_N),
		.set_evt   (irq_set),
		.clr_bits  (wr_ist ? PWDATA[i2csf_pkg::NUM_IRQ-1:0]
		                   : {i2csf_pkg::NUM_IRQ{1'b0}}),
		.mask_wr   (wr_imask),
		.mask_data (PWDATA[i2csf_pkg::NUM_IRQ-1:0]),
		.stat_reg  (irq_stat),
		.mask_reg  (irq_mask),
		.irq_reg   (irq_out)
	);

	// ==========================================================
	// Flag storage
	logic       enable_reg;
	logic       enable_next;
	logic       nack_seen_flag_reg;
	logic       nack_seen_flag_next;
	logic       master_tx_busy_flag_reg;
	logic       master_tx_busy_flag_next;
	logic       collision_flag_reg;
	logic       collision_flag_next;
	logic       general_call_hit_reg;
	logic       general_call_hit_next;
	logic       ten_bit_match_reg;
	logic       ten_bit_match_next;
	logic       write_collision_flag_reg;
	logic       write_collision_flag_next;
	logic       rx_overflow_flag_reg;
	logic       rx_overflow_flag_next;
	logic       data_addr_flag_reg;
	logic       data_addr_flag_next;
	logic       stop_seen_flag_reg;
	logic       stop_seen_flag_next;
	logic       start_seen_flag_reg;
	logic       start_seen_flag_next;
	logic       read_dir_flag_reg;
	logic       read_dir_flag_next;
	logic       rx_full_flag_reg;
	logic       rx_full_flag_next;
	logic       tx_full_flag_reg;
	logic       tx_full_flag_next;
	logic [7:0] tx_holding_reg;
	logic [7:0] tx_holding_next;
	logic [7:0] rx_holding_reg;
	logic [7:0] rx_holding_next;

	// ==========================================================
	// Control: dropping the enable is the only way out of a collision
	assign enable_next = wr_ctrl ? PWDATA[i2csf_pkg::BIT_ENABLE]
	                             : enable_reg;
	wire disable_now = wr_ctrl & ~PWDATA[i2csf_pkg::BIT_ENABLE];

	// ==========================================================
	// Master flags
	assign nack_seen_flag_next = EVT.ack_done ? EVT.ack_nack  // [R1]
	                                          : nack_seen_flag_reg;
	// A new start beats the acknowledge end in the same cycle
	assign master_tx_busy_flag_next =
		EVT.mtx_start | (master_tx_busy_flag_reg & ~EVT.ack_done); // [R2]
	assign collision_flag_next =
		EVT.collision | (collision_flag_reg & ~disable_now); // [R3]

	// ==========================================================
	// Address match flags, cleared by a stop; match wins a tie
	assign general_call_hit_next =
		EVT.gc_match | (general_call_hit_reg & ~stop_pulse); // [R4]
	assign ten_bit_match_next =
		EVT.ten_match | (ten_bit_match_reg & ~stop_pulse); // [R5]

	// ==========================================================
	// Transmit holding register
	wire tx_reject = wr_txd & EVT.busy;
	wire tx_accept = wr_txd & ~EVT.busy;

	// Status writes only clear bits written as zero
	wire clr_wr_coll = wr_status & ~PWDATA[i2csf_pkg::BIT_WR_COLL];
	wire clr_rx_ovf  = wr_status & ~PWDATA[i2csf_pkg::BIT_RX_OVF];

	assign tx_holding_next = tx_accept ? PWDATA[7:0] // [R6]
	                                   : tx_holding_reg;
	assign write_collision_flag_next =
		tx_reject | (write_collision_flag_reg & ~clr_wr_coll); // [R6] [R15]
	assign tx_full_flag_next =
		tx_accept | (tx_full_flag_reg & ~EVT.tx_done); // [R13]

	// ==========================================================
	// Receive holding register; an unread byte is kept, the new one
	// is dropped, so software never loses the older data silently
	wire rx_load = EVT.rx_valid & (~rx_full_flag_reg | rd_rxd);
	wire rx_ovf  = EVT.rx_valid & rx_full_flag_reg & ~rd_rxd;

	assign rx_holding_next = rx_load ? EVT.rx_data : rx_holding_reg;
	assign rx_overflow_flag_next =
		rx_ovf | (rx_overflow_flag_reg & ~clr_rx_ovf); // [R7] [R15]
	assign rx_full_flag_next =
		rx_load | (rx_full_flag_reg & ~rd_rxd); // [R12]

	// ==========================================================
	// Slave byte kind and direction
	assign data_addr_flag_next =
		EVT.addr_match ? 1'b0 : // [R8]
		(EVT.rx_valid ? 1'b1 : data_addr_flag_reg); // [R8]
	assign read_dir_flag_next = EVT.addr_match ? EVT.rw_bit // [R11]
	                                           : read_dir_flag_reg;

	// ==========================================================
	// Last bus condition
	assign stop_seen_flag_next  = stop_pulse  ? 1'b1 : // [R9]
	                              (start_pulse ? 1'b0 : stop_seen_flag_reg);
	assign start_seen_flag_next = start_pulse ? 1'b1 : // [R10]
	                              (stop_pulse  ? 1'b0 : start_seen_flag_reg);

	// ==========================================================
	// Interrupt sources
	assign irq_set[i2csf_pkg::IRQ_NACK]    = EVT.ack_done & EVT.ack_nack;
	assign irq_set[i2csf_pkg::IRQ_RX_LOAD] = rx_load;
	assign irq_set[i2csf_pkg::IRQ_TX_DONE] = EVT.tx_done;
	assign irq_set[i2csf_pkg::IRQ_START]   = start_pulse;
	assign irq_set[i2csf_pkg::IRQ_STOP]    = stop_pulse;
	assign irq_set[i2csf_pkg::IRQ_COLL]    = EVT.collision;
	assign irq_set[i2csf_pkg::IRQ_WR_COLL] = tx_reject;
	assign irq_set[i2csf_pkg::IRQ_RX_OVF]  = rx_ovf;

	// ==========================================================
	// Status word; every bit not listed stays zero
	logic [31:0] status_word;
	always_comb begin
		status_word = i2csf_pkg::WORD_ZERO; // [R14]
		status_word[i2csf_pkg::BIT_NACK_SEEN]  = nack_seen_flag_reg;
		status_word[i2csf_pkg::BIT_MTX_BUSY]   = master_tx_busy_flag_reg;
		status_word[i2csf_pkg::BIT_COLLISION]  = collision_flag_reg;
		status_word[i2csf_pkg::BIT_GEN_CALL]   = general_call_hit_reg;
		status_word[i2csf_pkg::BIT_TEN_MATCH]  = ten_bit_match_reg;
		status_word[i2csf_pkg::BIT_WR_COLL]    = write_collision_flag_reg;
		status_word[i2csf_pkg::BIT_RX_OVF]     = rx_overflow_flag_reg;
		status_word[i2csf_pkg::BIT_DATA_ADDR]  = data_addr_flag_reg;
		status_word[i2csf_pkg::BIT_STOP_SEEN]  = stop_seen_flag_reg;
		status_word[i2csf_pkg::BIT_START_SEEN] = start_seen_flag_reg;
		status_word[i2csf_pkg::BIT_READ_DIR]   = read_dir_flag_reg;
		status_word[i2csf_pkg::BIT_RX_FULL]    = rx_full_flag_reg;
		status_word[i2csf_pkg::BIT_TX_FULL]    = tx_full_flag_reg;
	end

	// Read data is captured at the same edge that raises PREADY
	wire [31:0] rd_mux =
		hit_status ? status_word :
		hit_ctrl   ? {31'h0000_0000, enable_reg} :
		hit_txd    ? {24'h00_0000, tx_holding_reg} :
		hit_rxd    ? {24'h00_0000, rx_holding_reg} :
		hit_ist    ? {24'h00_0000, irq_stat} :
		hit_imask  ? {24'h00_0000, irq_mask} :
		             i2csf_pkg::WORD_ZERO;

	// ==========================================================
	// APB answer sequencer: one wait state, then PREADY
	always_comb begin
		state_next   = state_reg;
		pready_next  = 1'b0;
		pslverr_next = 1'b0;
		prdata_next  = prdata_reg;
		case (state_reg)
			ST_IDLE: begin
				if (PSEL && PENABLE) begin
					state_next   = ST_ANSWER;
					pready_next  = 1'b1;
					pslverr_next = ~hit_any;
					prdata_next  = PWRITE ? i2csf_pkg::WORD_ZERO : rd_mux;
				end
			end
			ST_ANSWER: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			state_reg   <= ST_IDLE;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= i2csf_pkg::WORD_ZERO;
		end else begin
			state_reg   <= state_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg  <= prdata_next;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin // [R15]
			enable_reg               <= 1'b0;
			nack_seen_flag_reg       <= 1'b0;
			master_tx_busy_flag_reg  <= 1'b0;
			collision_flag_reg       <= 1'b0;
			general_call_hit_reg     <= 1'b0;
			ten_bit_match_reg        <= 1'b0;
			write_collision_flag_reg <= 1'b0;
			rx_overflow_flag_reg     <= 1'b0;
			data_addr_flag_reg       <= 1'b0;
			stop_seen_flag_reg       <= 1'b0;
			start_seen_flag_reg      <= 1'b0;
			read_dir_flag_reg        <= 1'b0;
			rx_full_flag_reg         <= 1'b0;
			tx_full_flag_reg         <= 1'b0;
			tx_holding_reg           <= i2csf_pkg::BYTE_ZERO;
			rx_holding_reg           <= i2csf_pkg::BYTE_ZERO;
		end else begin
			enable_reg               <= enable_next;
			nack_seen_flag_reg       <= nack_seen_flag_next;
			master_tx_busy_flag_reg  <= master_tx_busy_flag_next;
			collision_flag_reg       <= collision_flag_next;
			general_call_hit_reg     <= general_call_hit_next;
			ten_bit_match_reg        <= ten_bit_match_next;
			write_collision_flag_reg <= write_collision_flag_next;
			rx_overflow_flag_reg     <= rx_overflow_flag_next;
			data_addr_flag_reg       <= data_addr_flag_next;
			stop_seen_flag_reg       <= stop_seen_flag_next;
			start_seen_flag_reg      <= start_seen_flag_next;
			read_dir_flag_reg        <= read_dir_flag_next;
			rx_full_flag_reg         <= rx_full_flag_next;
			tx_full_flag_reg         <= tx_full_flag_next;
			tx_holding_reg           <= tx_holding_next;
			rx_holding_reg           <= rx_holding_next;
		end
	end

	// ==========================================================
	// Outputs, all straight from flip-flops
	assign PRDATA  = prdata_reg;
	assign PREADY  = pready_reg;
	assign PSLVERR = pslverr_reg;
	assign ENABLE  = enable_reg;
	assign TX_DATA = tx_holding_reg;
	assign TX_FULL = tx_full_flag_reg;
	assign IRQ     = irq_out;

endmodule

`default_nettype wire

// ===== i2csf_top_tb.sv
// Self-checking bench for the status flag block over APB.
// Assumes the bus model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module i2csf_top_tb;
	// ==========================================================
	// Signals
	logic                  MCLK = 1'b0;
	logic                  RST_N = 1'b0;
	logic                  PSEL = 1'b0;
	logic                  PENABLE = 1'b0;
	logic                  PWRITE = 1'b0;
	logic [7:0]            PADDR = 8'h00;
	logic [31:0]           PWDATA = 32'h0000_0000;
	logic [31:0]           PRDATA;
	logic                  PREADY, PSLVERR, SDA_IN, SCL_IN;
	logic                  ENABLE, TX_FULL, IRQ;
	logic [7:0]            TX_DATA;
	i2csf_pkg::i2csf_evt_t EVT;
	logic [32:0]           exp_q[$];
	logic [31:0]           st;
	logic [7:0]            b;
	integer                seed = 32'hd1c1;
	int                    fails = 0;
	int                    comparisons = 0;
	always #5 MCLK = ~MCLK;
	i2csf_top i_i2csf_top (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SDA_IN(SDA_IN),
		.SCL_IN(SCL_IN), .EVT(EVT), .ENABLE(ENABLE), .TX_DATA(TX_DATA),
		.TX_FULL(TX_FULL), .IRQ(IRQ));
	i2csf_bus_model i_i2csf_bus_model (.clk(MCLK), .sda(SDA_IN),
		.scl(SCL_IN), .evt(EVT));
	// ==========================================================
	// Tasks
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		do
			@(posedge MCLK);
		while (PREADY !== 1'b1);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge MCLK);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] x);
		exp_q.push_back(x);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	task automatic rs();
		rd(i2csf_pkg::OFS_STATUS, {1'b0, st});
	endtask
	task automatic ev(input i2csf_pkg::i2csf_evt_t x);
		i_i2csf_bus_model.pulse(x);
	endtask
	task automatic chk(input logic [32:0] got, input logic [32:0] x);
		comparisons++;
		if (got !== x) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, x);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d, fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Read data is taken at the completing edge only
	always @(posedge MCLK) begin
		if (PSEL && PENABLE && !PWRITE && PREADY === 1'b1)
			chk({PSLVERR, PRDATA}, exp_q.pop_front());
	end
	initial begin
		repeat (20000) @(posedge MCLK);
		fails++;
		stop_test();
	end
	// ==========================================================
	// Scenarios
	initial begin
		st = 32'h0000_0000;
		repeat (6) @(posedge MCLK);
		RST_N <= 1'b1;
		@(posedge MCLK);
		rs();
		apb(1'b1, i2csf_pkg::OFS_STATUS, $random(seed));
		rs();
		rd(8'h18, 33'h1_0000_0000);
		apb(1'b1, i2csf_pkg::OFS_CTRL, 32'h0000_0001);
		rd(i2csf_pkg::OFS_CTRL, 33'h0_0000_0001);
		$display("test reset finished");
		for (int i = 0; i < 2; i++) begin
			i_i2csf_bus_model.start();
			st[4:3] = 2'b01;
			rs();
			i_i2csf_bus_model.stop();
			st[4:3] = 2'b10;
			rs();
		end
		$display("test conditions finished");
		for (int n = 1; n >= 0; n--) begin
			b = $random(seed);
			apb(1'b1, i2csf_pkg::OFS_TXD, {24'h00_0000, b});
			st[0] = 1'b1;
			rs();
			ev('{mtx_start: 1'b1, busy: 1'b1, default: '0});
			apb(1'b1, i2csf_pkg::OFS_TXD, ~{24'h00_0000, b});
			st[14] = 1'b1;
			st[7] = 1'b1;
			rs();
			rd(i2csf_pkg::OFS_TXD, {25'h000_0000, b});
			ev('{ack_done: 1'b1, ack_nack: n[0], busy: 1'b1, default: '0});
			ev('{tx_done: 1'b1, default: '0});
			st[15:14] = {n[0], 1'b0};
			st[0] = 1'b0;
			rs();
			apb(1'b1, i2csf_pkg::OFS_STATUS, 32'h0000_0000);
			st[7] = 1'b0;
			rs();
		end
		$display("test master transmit finished");
		apb(1'b1, i2csf_pkg::OFS_INT_STAT, 32'h0000_00FF);
		apb(1'b1, i2csf_pkg::OFS_INT_MASK, 32'h0000_0020);
		rd(i2csf_pkg::OFS_INT_MASK, 33'h0_0000_0020);
		ev('{collision: 1'b1, default: '0});
		st[10] = 1'b1;
		repeat (2) @(posedge MCLK);
		chk(IRQ, 33'h0_0000_0001);
		apb(1'b1, i2csf_pkg::OFS_STATUS, 32'h0000_0000);
		rs();
		rd(i2csf_pkg::OFS_INT_STAT, 33'h0_0000_0020);
		apb(1'b1, i2csf_pkg::OFS_INT_MASK, 32'h0000_0000);
		// Irq flop follows the mask one edge after the write lands
		@(posedge MCLK);
		chk(IRQ, 33'h0_0000_0000);
		apb(1'b1, i2csf_pkg::OFS_CTRL, 32'h0000_0000);
		st[10] = 1'b0;
		rs();
		apb(1'b1, i2csf_pkg::OFS_CTRL, 32'h0000_0001);
		apb(1'b1, i2csf_pkg::OFS_INT_STAT, 32'h0000_0020);
		rd(i2csf_pkg::OFS_INT_STAT, 33'h0_0000_0000);
		$display("test collision finished");
		for (int r = 0; r < 2; r++) begin
			i_i2csf_bus_model.start();
			ev('{addr_match: 1'b1, rw_bit: r[0], gc_match: 1'b1,
				ten_match: 1'b1, default: '0});
			st[9:8] = 2'b11;
			st[5:2] = {1'b0, 2'b01, r[0]};
			rs();
			b = $random(seed);
			ev('{rx_valid: 1'b1, rx_data: b, default: '0});
			ev('{rx_valid: 1'b1, rx_data: ~b, default: '0});
			st[6:5] = 2'b11;
			st[1] = 1'b1;
			rs();
			rd(i2csf_pkg::OFS_RXD, {25'h000_0000, b});
			st[1] = 1'b0;
			rs();
			apb(1'b1, i2csf_pkg::OFS_STATUS, 32'h0000_0000);
			st[6] = 1'b0;
			i_i2csf_bus_model.stop();
			st[9:8] = 2'b00;
			st[4:3] = 2'b10;
			rs();
		end
		$display("test slave receive finished");
		stop_test();
	end
endmodule
`default_nettype wire
